//--- hw/word_load_pkg.sv
package word_load_pkg;

    // instruction fields
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int BASE_HI = 25;
    localparam int BASE_LO = 21;
    localparam int TGT_HI = 20;
    localparam int TGT_LO = 16;
    localparam int OFS_HI = 15;
    localparam int OFS_LO = 0;

    // major opcodes
    localparam logic [5:0] OPC_LOAD_WORD_SIGNED = 6'h23;
    localparam logic [5:0] OPC_LOAD_WORD_UPPER_PART = 6'h22;

    // access length: bytes minus one
    localparam logic [1:0] LEN_WORD = 2'h3;

    // exception codes
    localparam logic [1:0] EXC_NONE = 2'h0;
    localparam logic [1:0] EXC_ADDRESS = 2'h1;
    localparam logic [1:0] EXC_TLB_REFILL = 2'h2;
    localparam logic [1:0] EXC_TLB_INVALID = 2'h3;

    // reset values
    localparam logic [63:0] RST_DATA = 64'h0000_0000_0000_0000;
    localparam logic [4:0] RST_INDEX = 5'h00;

    typedef enum logic {ST_IDLE, ST_WAIT} load_state_t;

endpackage : word_load_pkg

//--- hw/word_part_merge.sv
`timescale 1ns/1ps

module word_part_merge
(
    // data in
    input wire logic [31:0] mem_word,
    input wire logic [31:0] old_word,
    input wire logic [1:0] top_count,
    // data out
    output logic [31:0] merged
);

    genvar j;
    generate
        for (j = 0; j < 4; j++)
        begin : g_lane
            logic [2:0] sum;
            logic [1:0] src;
            assign sum = 3'(j) + {1'b0, top_count};
            assign src = sum[1:0] + 2'h1;
            // lane j takes memory when j >= 3 - top_count
            assign merged[8*j +: 8] = (sum >= 3'h3) ?
                mem_word[8*src +: 8] : old_word[8*j +: 8];
        end
    endgenerate

endmodule : word_part_merge

//--- hw/word_load_align_unit.sv
`timescale 1ns/1ps

// What this block does
// - aligned signed word load decoded from opcode 100011, base/target/offset.
// - address is sign-extended 16-bit offset plus base low 32 bits.
// - aligned load fetches 32-bit word, sign-extends to 64, writes target.
// - aligned load with nonzero low address bits: address error, no write.
// - upper-part load decoded from opcode 100010 with the same fields.
// - upper-part address names the top byte of a maybe-unaligned word.
// - upper-part load moves one to four bytes from the aligned word.
// - addressed byte lands in byte 3, fills downward, then sign-extends.
// - low register bytes not receiving memory bytes stay unchanged.
// - pending load result forwarded so back-to-back partial loads work.
// - upper-part load never raises an alignment error.
// - little-endian, low bits 0: length 0, one byte into byte 3.
// - little-endian: access length equals the low two address bits.
// - type sent with each request is access length, bytes minus one.
module word_load_align_unit
    import word_load_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // instruction issue
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [63:0] base_value,
    input wire logic [63:0] target_value,
    input wire logic cpu_byte_order_flag,
    output logic busy_q,
    // memory request
    output logic mem_req_valid_q,
    output logic [31:0] mem_req_virtual_address_q,
    output logic [1:0] mem_req_len_q,
    // memory response
    input wire logic mem_rsp_valid,
    input wire logic [127:0] mem_rsp_data,
    input wire logic mem_rsp_tlb_refill,
    input wire logic mem_rsp_tlb_invalid,
    // register write-back
    output logic wr_valid_q,
    output logic [4:0] wr_index_q,
    output logic [63:0] wr_data_q,
    // exceptions
    output logic exc_valid_q,
    output logic [1:0] exc_code_q
);

    ////////////////////////////////////////////////////////////////////////
    // decode and address

    load_state_t state_q;
    logic [5:0] opcode;
    logic [4:0] base_idx;
    logic [4:0] tgt_idx;
    logic [15:0] offset;
    logic is_signed_load;
    logic is_upper_load;
    logic take;
    logic [63:0] base_fwd;
    logic [63:0] tgt_fwd;
    logic [31:0] virtual_address;
    logic misaligned;
    logic [1:0] part_len;
    logic [1:0] word_sel;
    logic fwd_valid_q;
    logic [4:0] fwd_idx_q;
    logic [63:0] fwd_data_q;
    logic upper_q;
    logic big_q;
    logic [1:0] wsel_q;
    logic [31:0] old_q;
    logic [31:0] mem_word;
    logic [31:0] merged;
    logic [31:0] low_word;

    assign opcode = instr_word[OPC_HI:OPC_LO];
    assign base_idx = instr_word[BASE_HI:BASE_LO];
    assign tgt_idx = instr_word[TGT_HI:TGT_LO];
    assign offset = instr_word[OFS_HI:OFS_LO];
    assign is_signed_load = (opcode == OPC_LOAD_WORD_SIGNED);
    assign is_upper_load = (opcode == OPC_LOAD_WORD_UPPER_PART);
    assign take = instr_valid && (state_q == ST_IDLE) &&
        (is_signed_load || is_upper_load);

    // last written result beats the possibly stale register file
    // the write-back leaving this edge is not in the register file yet
    assign base_fwd = (wr_valid_q && wr_index_q == base_idx) ? wr_data_q :
        (fwd_valid_q && fwd_idx_q == base_idx) ? fwd_data_q : base_value;
    assign tgt_fwd = (wr_valid_q && wr_index_q == tgt_idx) ? wr_data_q :
        (fwd_valid_q && fwd_idx_q == tgt_idx) ? fwd_data_q : target_value;

    assign virtual_address = base_fwd[31:0] +
        {{16{offset[15]}}, offset};
    assign misaligned = is_signed_load &&
        (virtual_address[1:0] != 2'h0);
    // bytes minus one of the aligned word at or below the address (little-endian), at or above it (big-endian)
    assign part_len = virtual_address[1:0] ^
        {2{cpu_byte_order_flag}};
    assign word_sel = virtual_address[3:2] ^ {2{cpu_byte_order_flag}};

    ////////////////////////////////////////////////////////////////////////
    // sequencing

    always_ff @(posedge clock)
    begin
        if (srst)
            state_q <= ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (take && !misaligned)
                        state_q <= ST_WAIT;
                ST_WAIT:
                    if (mem_rsp_valid)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            busy_q <= 1'b0;
        else if (take && !misaligned)
            busy_q <= 1'b1;
        else if (state_q == ST_WAIT && mem_rsp_valid)
            busy_q <= 1'b0;
    end

    // request is a single-cycle pulse; address and length hold after it
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            mem_req_valid_q <= 1'b0;
            mem_req_virtual_address_q <= RST_DATA[31:0];
            mem_req_len_q <= 2'h0;
        end
        else
        begin
            mem_req_valid_q <= take && !misaligned;
            if (take && !misaligned)
            begin
                mem_req_virtual_address_q <= virtual_address;
                mem_req_len_q <= is_signed_load ?
                    LEN_WORD : part_len;
            end
        end
    end

    // context of the load in flight
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            upper_q <= 1'b0;
            big_q <= 1'b0;
            wsel_q <= 2'h0;
            old_q <= RST_DATA[31:0];
            wr_index_q <= RST_INDEX;
        end
        else if (take)
        begin
            upper_q <= is_upper_load;
            big_q <= cpu_byte_order_flag;
            wsel_q <= word_sel;
            old_q <= tgt_fwd[31:0];
            wr_index_q <= tgt_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data path

    assign mem_word = mem_rsp_data[{wsel_q, 5'h00} +: 32];

    word_part_merge u_merge
    (
        .mem_word(mem_word),
        .old_word(old_q),
        .top_count(mem_req_len_q),
        .merged(merged)
    );

    // upper-part loads merge memory bytes into the old target word; word loads take the memory word whole
    assign low_word = upper_q ? merged : mem_word;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wr_valid_q <= 1'b0;
            wr_data_q <= RST_DATA;
        end
        else
        begin
            wr_valid_q <= (state_q == ST_WAIT) && mem_rsp_valid &&
                !mem_rsp_tlb_refill && !mem_rsp_tlb_invalid;
            if (state_q == ST_WAIT && mem_rsp_valid)
                wr_data_q <= {{32{low_word[31]}}, low_word};
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            exc_valid_q <= 1'b0;
            exc_code_q <= EXC_NONE;
        end
        else if (take && misaligned)
        begin
            exc_valid_q <= 1'b1;
            exc_code_q <= EXC_ADDRESS;
        end
        else if (state_q == ST_WAIT && mem_rsp_valid &&
            (mem_rsp_tlb_refill || mem_rsp_tlb_invalid))
        begin
            exc_valid_q <= 1'b1;
            // refill is the more basic miss, report it first
            exc_code_q <= mem_rsp_tlb_refill ?
                EXC_TLB_REFILL : EXC_TLB_INVALID;
        end
        else
        begin
            exc_valid_q <= 1'b0;
            exc_code_q <= EXC_NONE;
        end
    end

    // forwarding only tracks this unit's own write-backs
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            fwd_valid_q <= 1'b0;
            fwd_idx_q <= RST_INDEX;
            fwd_data_q <= RST_DATA;
        end
        else if (wr_valid_q)
        begin
            fwd_valid_q <= 1'b1;
            fwd_idx_q <= wr_index_q;
            fwd_data_q <= wr_data_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_issue_signed;
        take && is_signed_load;
    endsequence

    sequence s_issue_upper;
        take && is_upper_load;
    endsequence

    property p_signed_decode;
        @(posedge clock) disable iff (srst)
        instr_valid && !busy_q && opcode == 6'h23 |=>
            mem_req_valid_q || exc_code_q == EXC_ADDRESS;
    endproperty
    a_signed_decode: assert property (p_signed_decode)
        else $error("aligned load opcode not decoded");

    // a following load may legally write back three edges later
    property p_misaligned_error;
        @(posedge clock) disable iff (srst)
        s_issue_signed ##0 (virtual_address[1:0] != 2'h0) |=>
            exc_valid_q && exc_code_q == EXC_ADDRESS && !mem_req_valid_q &&
            !wr_valid_q ##1 !wr_valid_q;
    endproperty
    a_misaligned_error: assert property (p_misaligned_error)
        else $error("misaligned word load not trapped");

    property p_upper_no_align_error;
        @(posedge clock) disable iff (srst)
        s_issue_upper |=> !exc_valid_q && mem_req_valid_q;
    endproperty
    a_upper_no_align_error: assert property (p_upper_no_align_error)
        else $error("upper part load raised alignment error");

    property p_address;
        @(posedge clock) disable iff (srst)
        take && !misaligned |=> mem_req_virtual_address_q ==
            $past(base_fwd[31:0]) + {{16{$past(offset[15])}}, $past(offset)};
    endproperty
    a_address: assert property (p_address)
        else $error("effective address wrong");

    property p_len_little;
        @(posedge clock) disable iff (srst)
        s_issue_upper ##0 !cpu_byte_order_flag |=>
            mem_req_len_q == mem_req_virtual_address_q[1:0];
    endproperty
    a_len_little: assert property (p_len_little)
        else $error("little-endian access length wrong");

    property p_len_big;
        @(posedge clock) disable iff (srst)
        s_issue_upper ##0 cpu_byte_order_flag |=>
            mem_req_len_q == 2'h3 - mem_req_virtual_address_q[1:0];
    endproperty
    a_len_big: assert property (p_len_big)
        else $error("big-endian access length wrong");

    property p_len_word;
        @(posedge clock) disable iff (srst)
        s_issue_signed ##0 !misaligned |=> mem_req_len_q == 2'h3;
    endproperty
    a_len_word: assert property (p_len_word)
        else $error("word load length not three");

    property p_sign_extend;
        @(posedge clock) disable iff (srst)
        wr_valid_q |-> wr_data_q[63:32] == {32{wr_data_q[31]}};
    endproperty
    a_sign_extend: assert property (p_sign_extend)
        else $error("result not sign extended");

    property p_keep_low;
        @(posedge clock) disable iff (srst)
        wr_valid_q && upper_q && !big_q && mem_req_len_q == 2'h0 |->
            wr_data_q[23:0] == old_q[23:0];
    endproperty
    a_keep_low: assert property (p_keep_low)
        else $error("unloaded low bytes changed");

    property p_fault;
        @(posedge clock) disable iff (srst)
        busy_q && mem_rsp_valid && (mem_rsp_tlb_refill || mem_rsp_tlb_invalid)
            |=> exc_valid_q && !wr_valid_q && !busy_q;
    endproperty
    a_fault: assert property (p_fault)
        else $error("translation fault wrote register");

    property p_forward;
        @(posedge clock) disable iff (srst)
        take && wr_valid_q && wr_index_q == tgt_idx |=>
            old_q == $past(wr_data_q[31:0]);
    endproperty
    a_forward: assert property (p_forward)
        else $error("target bypass missed write-back");

endmodule : word_load_align_unit

//--- testbench/mem_quad_model.sv
`timescale 1ns/1ps

module mem_quad_model
(
    // request side
    input wire logic clock,
    input wire logic req,
    input wire logic [31:0] addr,
    input wire logic be,
    input wire logic [1:0] flt,
    input wire logic [3:0] dly,
    // response side
    output logic rsp,
    output logic [127:0] data,
    output logic refill,
    output logic inval
);
    logic [31:0] a;
    logic [3:0] k;

    initial
    begin
        rsp = 0;
        data = 128'h0;
        refill = 0;
        inval = 0;
    end

    // released lines invert so stale data never looks valid
    always
    begin
        @(posedge clock);
        if (req === 1'b1)
        begin
            a = addr;
            repeat (dly) @(posedge clock);
            #1;
            for (int i = 0; i < 16; i++)
            begin
                k = i[3:0];
                data[8*i+:8] = {a[7:4], be ? ~k : k} ^ 8'h96;
            end
            {refill, inval} = flt;
            rsp = 1;
            @(posedge clock);
            #1;
            rsp = 0;
            data = ~data;
            {refill, inval} = ~flt;
        end
    end
endmodule : mem_quad_model

//--- testbench/test_word_load_align_unit.sv
`timescale 1ns/1ps

module test_word_load_align_unit
    import word_load_pkg::*;
;
    logic clock = 0, srst = 1, iv = 0, be = 0;
    logic [31:0] iw = 0, va;
    logic [63:0] bv = 0, tv = 0, wd;
    logic [1:0] flt = 0, len, ec;
    logic [3:0] dly = 0;
    logic busy, req, rsp, rf, ri, wv, ev;
    logic [127:0] rd;
    logic [4:0] wi;
    int n_mismatch = 0, total_checks = 0;

    always #50 clock = ~clock;

    word_load_align_unit dut (.clock(clock), .srst(srst), .instr_valid(iv),
        .instr_word(iw), .base_value(bv), .target_value(tv),
        .cpu_byte_order_flag(be), .busy_q(busy), .mem_req_valid_q(req),
        .mem_req_virtual_address_q(va), .mem_req_len_q(len), .mem_rsp_valid(rsp),
        .mem_rsp_data(rd), .mem_rsp_tlb_refill(rf), .mem_rsp_tlb_invalid(ri),
        .wr_valid_q(wv), .wr_index_q(wi), .wr_data_q(wd), .exc_valid_q(ev),
        .exc_code_q(ec));
    mem_quad_model mem (.clock(clock), .req(req), .addr(va), .be(be),
        .flt(flt), .dly(dly), .rsp(rsp), .data(rd), .refill(rf), .inval(ri));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] mb(logic [31:0] x);
        return x[7:0] ^ 8'h96;
    endfunction : mb

    function automatic logic [63:0] whole(logic [31:0] a);
        logic [31:0] w;
        w = be ? {mb(a), mb(a + 1), mb(a + 2), mb(a + 3)}
               : {mb(a + 3), mb(a + 2), mb(a + 1), mb(a)};
        return {{32{w[31]}}, w};
    endfunction : whole

    // big-endian walks up from the addressed byte, little walks down
    function automatic logic [63:0] upper(logic [31:0] a, logic [63:0] o);
        logic [31:0] w, x;
        w = o[31:0];
        for (int n = 0; n < 4; n++)
        begin
            x = be ? a + n : a - n;
            if (x[31:2] == a[31:2])
                w[8*(3-n)+:8] = mb(x);
        end
        return {{32{w[31]}}, w};
    endfunction : upper

    ////////////////////////////////////////////////////////////////////////
    task automatic run(logic [5:0] op, logic [4:0] tg, logic [15:0] of,
        logic [63:0] old, logic [1:0] xc, logic [63:0] exp);
        int i;
        logic [31:0] ea;
        logic [1:0] ln;
        ea = bv[31:0] + {{16{of[15]}}, of};
        ln = (op == OPC_LOAD_WORD_SIGNED) ? LEN_WORD : ea[1:0] ^ {be, be};
        iw = {op, 5'h07, tg, of};
        tv = old;
        iv = 1;
        @(posedge clock);
        #1;
        iv = 0;
        check("request", req, xc != EXC_ADDRESS);
        if (req === 1'b1)
        begin
            check("address", va, ea);
            check("length", len, ln);
        end
        i = 0;
        // a second offer while busy must be ignored
        while (wv !== 1'b1 && ev !== 1'b1 && i < 40)
        begin
            iv = (i == 0);
            @(posedge clock);
            #1;
            i++;
        end
        if (i >= 40)
        begin
            check("timeout", 0, 1);
            wrap_up();
        end
        // no gap: the next call is taken on the edge after write-back
        check("idle", {busy, req}, 0);
        check("exception", ev, xc != EXC_NONE);
        check("exc code", ec, xc);
        check("write", wv, xc == EXC_NONE);
        if (xc == EXC_NONE)
        begin
            check("index", wi, tg);
            check("data", wd, exp);
        end
    endtask : run

    task automatic t_ignored();
        iw = 32'h8000_0000;
        iv = 1;
        @(posedge clock);
        #1;
        iv = 0;
        check("ignored", {busy, req, ev}, 0);
    endtask : t_ignored

    task automatic t_aligned();
        bv = 64'hffff_ffff_0000_1ff0;
        for (int b = 0; b < 2; b++)
        begin
            be = b[0];
            dly = b ? 4'h3 : 4'h0;
            run(OPC_LOAD_WORD_SIGNED, 5'h03, 16'h0018, 64'h0, EXC_NONE,
                whole(32'h0000_2008));
            run(OPC_LOAD_WORD_SIGNED, 5'h1f, 16'hfff4, 64'h0, EXC_NONE,
                whole(32'h0000_1fe4));
        end
        dly = 0;
    endtask : t_aligned

    task automatic t_misaligned();
        bv = 64'h0000_0000_0000_1000;
        for (int lo = 1; lo < 4; lo++)
            run(OPC_LOAD_WORD_SIGNED, 5'h04, 16'h0010 + 16'(lo), 64'h0,
                EXC_ADDRESS, 64'h0);
    endtask : t_misaligned

    task automatic t_upper();
        logic [63:0] o;
        o = 64'h0123_4567_89ab_cdef;
        bv = 64'h0000_0000_0000_3000;
        for (int b = 0; b < 2; b++)
            for (int lo = 0; lo < 4; lo++)
            begin
                be = b[0];
                run(OPC_LOAD_WORD_UPPER_PART, 5'(16 + 4 * b + lo),
                    16'h0020 + 16'(lo), o, EXC_NONE,
                    upper(32'h0000_3020 + lo, o));
            end
    endtask : t_upper

    task automatic t_forward();
        logic [63:0] r;
        be = 0;
        bv = 64'h0000_0000_0000_4000;
        r = upper(32'h0000_4001, 64'h0);
        run(OPC_LOAD_WORD_UPPER_PART, 5'h09, 16'h0001, 64'h0, EXC_NONE, r);
        // stale register file value: result must come from the bypass
        run(OPC_LOAD_WORD_UPPER_PART, 5'h09, 16'h0006,
            64'h5555_5555_5555_5555, EXC_NONE,
            upper(32'h0000_4006, r));
    endtask : t_forward

    task automatic t_fault();
        bv = 64'h0000_0000_0000_5000;
        for (int j = 0; j < 2; j++)
            for (int f = 1; f < 4; f++)
            begin
                flt = f[1:0];
                run(j ? OPC_LOAD_WORD_UPPER_PART : OPC_LOAD_WORD_SIGNED,
                    5'h0a, 16'h0004, 64'h0,
                    f == 1 ? EXC_TLB_INVALID : EXC_TLB_REFILL,
                    64'h0);
            end
        flt = 0;
    endtask : t_fault

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clock);
        #1;
        srst = 0;
        check("reset", {busy, req, wv, ev, ec}, 0);
        t_ignored();
        t_aligned();
        t_misaligned();
        t_upper();
        t_forward();
        t_fault();
        wrap_up();
    end
endmodule : test_word_load_align_unit
